// *** hdl/mcr_pkg.sv ***
/*
 * Package for the mux connect and timeout register bank: offsets, field
 * positions, reset values, timeout counts and the register bus carrier.
 * Assumes a 100 MHz core clock for the stuck-low timer.
 */
package mcr_pkg;

    localparam logic [7:0] OFS_CONN_CONFIG   = 8'h02;
    localparam logic [7:0] OFS_SWITCH_STATE  = 8'h03;

    localparam int BIT_CONN_REQ      = 5;
    localparam int BIT_MASS_WRITE    = 2;
    localparam int BIT_TIMEOUT_HI    = 1;
    localparam int BIT_TIMEOUT_LO    = 0;
    localparam int BIT_SW_ONE        = 7;
    localparam int BIT_SW_TWO        = 6;
    localparam int BIT_LOGIC_ONE     = 3;
    localparam int BIT_LOGIC_TWO     = 2;

    localparam logic       RST_CONN_REQ   = 1'b0;
    localparam logic       RST_MASS_WRITE = 1'b1;
    localparam logic [1:0] RST_TIMEOUT    = 2'h0;
    localparam logic       RST_SWITCH     = 1'b0;

    localparam logic [6:0] MASS_WRITE_ADDR = 7'h5E;

    localparam int CLK_HZ          = 100_000_000;
    localparam int TIMEOUT_30_US   = 30_000;
    localparam int TIMEOUT_15_US   = 15_000;
    localparam int TIMEOUT_7P5_NS  = 7_500_000;
    localparam int CYC_30  = TIMEOUT_30_US * (CLK_HZ / 1_000_000);
    localparam int CYC_15  = TIMEOUT_15_US * (CLK_HZ / 1_000_000);
    localparam int CYC_7P5 = TIMEOUT_7P5_NS / (1_000_000_000 / CLK_HZ);

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcr_req_t;

endpackage

// *** hdl/mcr_regs.sv ***
/*
 * Connection-config and switch-state registers for a two-channel two-wire
 * multiplexer, the connection check and the stuck-low timeout.
 * Register access arrives as single-cycle write strobes and reads from the
 * bus slave on the upstream clock domain; the stuck-low timer runs on the
 * core clock and sees the downstream line levels through synchronisers.
 */
`timescale 1ns/1ps

module mcr_regs #(
    parameter int CYC_30  = mcr_pkg::CYC_30,
    parameter int CYC_15  = mcr_pkg::CYC_15,
    parameter int CYC_7P5 = mcr_pkg::CYC_7P5
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_ce,
    input  wire logic             i_upstream_clock,
    input  wire logic             i_enable,
    input  wire mcr_pkg::mcr_req_t i_req,
    input  wire logic             i_req_valid,
    input  wire logic [6:0]       i_dev_addr,
    input  wire logic             i_chan_one_data,
    input  wire logic             i_chan_one_clock,
    input  wire logic             i_chan_two_data,
    input  wire logic             i_chan_two_clock,
    input  wire logic             i_fail_clear,
    output logic [7:0]            o_rdata,
    output logic                  o_addr_match,
    output logic [1:0]            o_connect,
    output logic                  o_buffers_on,
    output logic                  o_ready_n,
    output logic                  o_fail_n,
    output logic                  o_timeout_now,
    output logic                  o_alert_n
);

    // Upstream domain: lines, enable
    logic [3:0] up_meta;
    logic [3:0] up_sync;
    logic [1:0] en_sync;
    logic       conn_req;
    logic       mass_write;
    logic [1:0] timeout_sel;
    logic [1:0] sw_state;
    logic       fail_n;
    logic [1:0] to_sync;
    logic [1:0] fc_sync;

    wire rst_up_n  = i_resetn & en_sync[1];
    wire lvl_one   = up_sync[0] & up_sync[1];
    wire lvl_two   = up_sync[2] & up_sync[3];
    wire [1:0] lvl = {lvl_two, lvl_one};
    wire wr_cfg    = i_req_valid & i_req.wr & (i_req.addr == mcr_pkg::OFS_CONN_CONFIG);
    wire wr_sw     = i_req_valid & i_req.wr & (i_req.addr == mcr_pkg::OFS_SWITCH_STATE);
    wire [1:0] want = {i_req.wdata[mcr_pkg::BIT_SW_TWO], i_req.wdata[mcr_pkg::BIT_SW_ONE]};
    // With conn_req clear only newly requested channels are checked; connected ones stay
    wire [1:0] grant = conn_req ? want : (want & (lvl | sw_state));
    wire refused    = wr_sw & ~conn_req & |(want & ~lvl & ~sw_state);

    always_ff @(posedge i_upstream_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            up_meta <= 4'h0;
            up_sync <= 4'h0;
            en_sync <= 2'h0;
        end
        else
        begin
            up_meta <= {i_chan_two_clock, i_chan_two_data, i_chan_one_clock, i_chan_one_data};
            up_sync <= up_meta;
            en_sync <= {en_sync[0], i_enable};
        end
    end

    always_ff @(posedge i_upstream_clock or negedge rst_up_n)
    begin
        if (!rst_up_n)
        begin
            conn_req    <= mcr_pkg::RST_CONN_REQ;
            mass_write  <= mcr_pkg::RST_MASS_WRITE;
            timeout_sel <= mcr_pkg::RST_TIMEOUT;
            sw_state    <= {2{mcr_pkg::RST_SWITCH}};
            fail_n      <= 1'b1;
            fc_sync     <= 2'h0;
        end
        else
        begin
            fc_sync <= {fc_sync[0], i_fail_clear};
            if (wr_cfg)
            begin
                conn_req    <= i_req.wdata[mcr_pkg::BIT_CONN_REQ];
                mass_write  <= i_req.wdata[mcr_pkg::BIT_MASS_WRITE];
                timeout_sel <= i_req.wdata[1:0];
            end
            if (wr_sw)
                sw_state <= grant;
            if (refused)
                fail_n <= 1'b0;
            else if (fc_sync[1])
                fail_n <= 1'b1;
        end
    end

    // Read mux; reserved bits zero
    wire [7:0] cfg_rd = {2'h0, conn_req, 2'h0, mass_write, timeout_sel};
    wire [7:0] sw_rd  = {sw_state[0], sw_state[1], 2'h0, lvl_one, lvl_two, 2'h0};

    always_ff @(posedge i_upstream_clock or negedge rst_up_n)
    begin
        if (!rst_up_n)
            o_rdata <= 8'h00;
        else if (i_req_valid & ~i_req.wr)
            o_rdata <= (i_req.addr == mcr_pkg::OFS_CONN_CONFIG)  ? cfg_rd :
                       (i_req.addr == mcr_pkg::OFS_SWITCH_STATE) ? sw_rd : 8'h00;
    end

    assign o_addr_match = en_sync[1] &
                          ((i_dev_addr == mcr_pkg::MASS_WRITE_ADDR) ? mass_write : 1'b0);

    // Core domain: stuck-low timer
    logic [3:0]  c_meta;
    logic [3:0]  c_sync;
    logic [1:0]  sel_meta;
    logic [1:0]  sel_c;
    logic [31:0] cnt;
    logic        tmo;
    logic        tmo_latched;
    // Switch state brought into the core domain; each bit is independent
    logic [1:0]  sw_meta;
    logic [1:0]  sw_core;
    logic [1:0]  lvl_core;

    wire any_conn  = |sw_state;

    // Per-channel idle check in the core domain
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            // Idle only while both lines of the channel are high
            assign lvl_core[ch] = c_sync[2 * ch] & c_sync[2 * ch + 1];
        end
    endgenerate

    // Stuck: a connected channel shows a low line
    wire stuck = |(sw_core & ~lvl_core);
    wire [31:0] limit = (sel_c == 2'h1) ? 32'(CYC_30)  :
                        (sel_c == 2'h2) ? 32'(CYC_15)  : 32'(CYC_7P5);

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            c_meta   <= 4'h0;
            c_sync   <= 4'h0;
            sel_meta <= 2'h0;
            sel_c    <= 2'h0;
            to_sync  <= 2'h0;
            sw_meta  <= 2'h0;
            sw_core  <= 2'h0;
        end
        else if (i_ce)
        begin
            c_meta   <= {i_chan_two_clock, i_chan_two_data, i_chan_one_clock, i_chan_one_data};
            c_sync   <= c_meta;
            sel_meta <= timeout_sel;
            sel_c    <= sel_meta;
            to_sync  <= {to_sync[0], i_enable};
            sw_meta  <= sw_state;
            sw_core  <= sw_meta;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cnt         <= 32'h0;
            tmo         <= 1'b0;
            tmo_latched <= 1'b0;
        end
        else if (i_ce)
        begin
            if (!to_sync[1] || sel_c == 2'h0 || !stuck)
            begin
                cnt <= 32'h0;
                tmo <= 1'b0;
            end
            else if (cnt + 32'h1 >= limit)
                tmo <= 1'b1;
            else
                cnt <= cnt + 32'h1;
            if (tmo)
                tmo_latched <= 1'b1;
            else if (!to_sync[1])
                tmo_latched <= 1'b0;
        end
    end

    // Switch bits kept; only the buffers drop on timeout
    assign o_connect     = sw_state;
    assign o_buffers_on  = any_conn & ~tmo_latched;
    assign o_ready_n     = ~o_buffers_on;
    assign o_fail_n      = fail_n;
    assign o_timeout_now = tmo;
    assign o_alert_n     = ~(tmo_latched | ~fail_n);

endmodule

// *** dv/mcr_regs_properties.sv ***
/* Port checker for the register bank.
   Assumes it is bound onto mcr_regs. */
`timescale 1ns/1ps
module mcr_regs_properties (
    input wire logic              i_core_clk,
    input wire logic              i_resetn,
    input wire logic              i_upstream_clock,
    input wire logic              i_enable,
    input wire mcr_pkg::mcr_req_t i_req,
    input wire logic              i_req_valid,
    input wire logic [6:0]        i_dev_addr,
    input wire logic [7:0]        o_rdata,
    input wire logic              o_addr_match,
    input wire logic [1:0]        o_connect,
    input wire logic              o_buffers_on,
    input wire logic              o_ready_n,
    input wire logic              o_fail_n,
    input wire logic              o_timeout_now,
    input wire logic              o_alert_n
);
    wire wr3 = i_req_valid && i_req.wr && i_req.addr == 8'h03;
    wire rd2 = i_req_valid && !i_req.wr && i_req.addr == 8'h02;
    wire rd3 = i_req_valid && !i_req.wr && i_req.addr == 8'h03;
    addr_match_a: assert property (@(posedge i_upstream_clock) disable iff (!i_resetn)
        o_addr_match |-> i_dev_addr == mcr_pkg::MASS_WRITE_ADDR) else $error("bad match");
    sw_one_a: assert property (@(posedge i_upstream_clock) disable iff (!i_resetn)
        wr3 && !i_req.wdata[7] |=> !o_connect[0]) else $error("switch one stuck");
    sw_two_a: assert property (@(posedge i_upstream_clock) disable iff (!i_resetn)
        wr3 && !i_req.wdata[6] |=> !o_connect[1]) else $error("switch two stuck");
    enable_reset_a: assert property (@(posedge i_upstream_clock) disable iff (!i_resetn)
        !i_enable [*3] |=> o_connect == 2'h0 && !o_addr_match) else $error("no reset");
    cfg_resv_a: assert property (@(posedge i_upstream_clock) disable iff (!i_resetn)
        rd2 |=> o_rdata[7:6] == 2'h0 && o_rdata[4:3] == 2'h0) else $error("cfg reserved");
    sw_resv_a: assert property (@(posedge i_upstream_clock) disable iff (!i_resetn)
        rd3 |=> o_rdata[5:4] == 2'h0 && o_rdata[1:0] == 2'h0) else $error("sw reserved");
    fail_alert_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !o_fail_n |-> !o_alert_n) else $error("fail without alert");
    bufs_need_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_buffers_on |-> o_connect != 2'h0 && !o_ready_n) else $error("buffers wrong");
    timeout_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_timeout_now |=> !o_buffers_on && !o_alert_n) else $error("timeout not latched");
    timer_min_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $rose(o_timeout_now) |-> $past(o_connect, 8) != 2'h0) else $error("early timeout");
endmodule
bind mcr_regs mcr_regs_properties i_mcr_regs_properties (.*);

// *** dv/mcr_master_model.sv ***
/* Upstream master: one register access at a time.
   Assumes requests are taken on the upstream clock. */
`timescale 1ns/1ps
module mcr_master_model (
    input  wire logic        i_upstream_clock,
    output mcr_pkg::mcr_req_t o_req,
    output logic             o_req_valid
);
    initial
    begin
        o_req       = '0;
        o_req_valid = 1'b0;
    end
    // Logic bits of connected channels are never trusted here
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_upstream_clock);
        #1;
        o_req       = '{wr, a, d};
        o_req_valid = 1'b1;
        @(posedge i_upstream_clock);
        #1;
        o_req_valid = 1'b0;
        o_req       = mcr_pkg::mcr_req_t'(~o_req);
    endtask
endmodule

// *** dv/mcr_regs_test.sv ***
/* Bench: defaults, connect checks, reserved bits, timeout codes.
   Assumes the master model issues all register traffic. */
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module mcr_regs_test;
    logic              core_clk = 1'b0;
    logic              uclk     = 1'b0;
    logic              resetn   = 1'b0;
    logic              enable   = 1'b1;
    logic [6:0]        dev_addr = 7'h5E;
    logic [3:0]        lines    = 4'hF;
    logic              fail_clr = 1'b0;
    mcr_pkg::mcr_req_t req;
    logic              req_valid;
    logic [7:0]        rdata;
    logic [1:0]        conn;
    logic              amatch, bon, rdyn, failn, tnow, alertn;
    int                n_mismatch = 0;
    int                n_compared = 0;
    initial forever #5 core_clk = ~core_clk;
    initial #3 forever #62.5 uclk = ~uclk;
    mcr_master_model i_mcr_master_model (.i_upstream_clock(uclk), .o_req(req),
        .o_req_valid(req_valid));
    mcr_regs #(.CYC_30(40), .CYC_15(20), .CYC_7P5(10)) i_mcr_regs (
        .i_core_clk(core_clk), .i_resetn(resetn), .i_ce(1'b1), .i_upstream_clock(uclk),
        .i_enable(enable), .i_req(req), .i_req_valid(req_valid), .i_dev_addr(dev_addr),
        .i_chan_one_data(lines[0]), .i_chan_one_clock(lines[1]),
        .i_chan_two_data(lines[2]), .i_chan_two_clock(lines[3]), .i_fail_clear(fail_clr),
        .o_rdata(rdata), .o_addr_match(amatch), .o_connect(conn), .o_buffers_on(bon),
        .o_ready_n(rdyn), .o_fail_n(failn), .o_timeout_now(tnow), .o_alert_n(alertn));
    task automatic settle;
        repeat (3) @(posedge uclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_mcr_master_model.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_mcr_master_model.xfer(1'b0, a, 8'h00);
        `CHK(rdata, e)
    endtask
    task automatic t_refuse;
        lines = 4'hE;
        settle();
        wr(8'h03, 8'hC0);
        `CHK(conn, 2'h2)
        `CHK({failn, alertn}, 2'b00)
        rd(8'h03, 8'h44);
        lines = 4'hF;
        fail_clr = 1'b1;
        settle();
        fail_clr = 1'b0;
        wr(8'h03, 8'h3F);
        `CHK(failn, 1'b1)
        rd(8'h03, 8'h0C);
        wr(8'h02, 8'hFB);
        `CHK(amatch, 1'b0)
        rd(8'h02, 8'h23);
    endtask
    task automatic t_timeout(input logic [1:0] code, input int lim);
        int n;
        enable = 1'b0;
        settle();
        enable = 1'b1;
        settle();
        rd(8'h02, 8'h04);
        lines = 4'hE;
        wr(8'h02, {6'h08, code});
        wr(8'h03, 8'hC0);
        `CHK(conn, 2'h3)
        n = 0;
        while (tnow !== 1'b1 && n < 80)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK(lim == 0 ? n == 80 : n >= lim && n <= lim + 5, 1'b1)
        @(posedge core_clk);
        #1;
        if (lim != 0)
            `CHK({bon, alertn, conn}, 4'h3)
        lines = 4'hF;
    endtask
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge uclk);
        #1;
        resetn = 1'b1;
        settle();
        rd(8'h02, 8'h04);
        rd(8'h03, 8'h0C);
        rd(8'h07, 8'h00);
        `CHK(amatch, 1'b1)
        t_refuse();
        t_timeout(2'h0, 0);
        t_timeout(2'h1, 40);
        t_timeout(2'h2, 20);
        t_timeout(2'h3, 10);
        results();
    end
endmodule
